// ==== rxq_pkg.sv ====
// Shared constants, register map and carrier types of the receiver quality block
package rxq_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LVL_W  = 8;
	localparam int SQI_W  = 6;
	localparam int SYNC_W = 32;

	// -------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_THRESH = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ANT    = 8'h08;
	localparam logic [ADDR_W-1:0] REG_SYNC0  = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_SYNC1  = 8'h10;
	localparam logic [ADDR_W-1:0] REG_CAPT   = 8'h14;
	localparam logic [ADDR_W-1:0] REG_RUN    = 8'h18;
	localparam logic [ADDR_W-1:0] REG_PQI    = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_SQI    = 8'h20;
	localparam logic [ADDR_W-1:0] REG_STAT   = 8'h24;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [DATA_W-1:0] CTRL_RST     = 32'h0000_0001;
	localparam logic [DATA_W-1:0] THRESH_RST   = 32'h0010_0000;
	localparam logic [DATA_W-1:0] ANT_RST      = 32'h0000_0000;
	localparam logic [DATA_W-1:0] SYNC_RST     = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CTRL_WMASK   = 32'h0000_003F;
	localparam logic [DATA_W-1:0] THRESH_WMASK = 32'h001F_FFFF;
	localparam logic [DATA_W-1:0] ANT_WMASK    = 32'h0000_007F;

	// Status and readback bit positions
	localparam int STAT_CS     = 0;
	localparam int STAT_ANT    = 1;
	localparam int STAT_PQV    = 2;
	localparam int STAT_SQV    = 3;
	localparam int SQI_SEC_BIT = 6;

	// -------------------------------------------------------------
	// Signal level and quality arithmetic
	// -------------------------------------------------------------
	// Level code zero sits this many dB below 0 dBm
	localparam int SIGNAL_OFFSET_DBM = 146;
	localparam logic [LVL_W:0] CS_HYST_DB     = 9'h003;
	localparam logic [LVL_W:0] CS_DYN_STEP_DB = 9'h006;
	localparam logic [LVL_W-1:0] PQI_INC      = 8'h01;
	localparam logic [LVL_W-1:0] PQI_DEC      = 8'h04;
	localparam logic [LVL_W-1:0] LVL_MAX      = 8'hFF;
	localparam int PREAMBLE_QUALITY_THRESHOLD_SHIFT = 2;
	localparam int SYNC_QUALITY_THRESHOLD_SHIFT = 1;
	localparam int MEAS_BASE    = 24;

	// -------------------------------------------------------------
	// Carrier types
	// -------------------------------------------------------------
	typedef struct packed {
		logic [25:0] rsvd;
		logic        ook;
		logic [1:0]  cs_mode;
		logic        blank_en;
		logic        antenna_diversity_enable;
		logic        sync_quality_check_enable;
	} ctrl_type;

	typedef struct packed {
		logic [10:0]      rsvd;
		logic [SQI_W-1:0] sync_word_length;
		logic [2:0]       sync_quality_threshold;
		logic [3:0]       preamble_quality_threshold;
		logic [LVL_W-1:0] signal_threshold;
	} thresh_type;

	typedef struct packed {
		logic [24:0] rsvd;
		logic [2:0]  antenna_measure_time_exp;
		logic [3:0]  channel_filter_setting;
	} ant_type;

	typedef struct packed {
		logic              rx_on;
		logic [LVL_W-1:0]  rssi;
		logic              bit_valid;
		logic              bit_val;
		logic              sync_end;
		logic              abort_command;
		logic              rx_timeout;
	} demod_type;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axil_req_type;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic [1:0]        bresp;
		logic              bvalid;
		logic              arready;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic              rvalid;
	} axil_rsp_type;

endpackage

// ==== rx_quality_indicators_antenna_diversity.sv ====
// Receiver quality indicators, carrier sense, blanking and antenna diversity
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Signal level is an 8-bit code in 1 dB steps, zero at -146 dBm.
// - Captured level latches on sync end, abort command or receive timeout.
// - Running level follows the signal-strength filter every cycle.
// - Each running level read returns a fresh value.
// - Static mode: assert above threshold, release 3 dB below it.
// - Dynamic modes: assert above threshold on 6/12/18 dB rise, release on fall.
// - Carrier sense output starts recovery and feeds listen-before-talk.
// - Preamble score adds 1 per bit change, subtracts 4 per repeat.
// - Preamble peak above four times threshold fires preamble valid once.
// - Sync quality is peak correlation of bit stream with expected word.
// - Checked sync valid fires when peak reaches length minus twice threshold.
// - Sync readback: peak in bits 5:0, bit 6 marks secondary word.
// - With blanking on, rx_data_valid is suppressed below signal threshold; rx_data still follows the bit.
// - Diversity alternates antennas until carrier sense, then keeps stronger one.
// - Antenna select drives a pin and status bit 1.
// - Measure interval is 24 shifted by filter exponent plus time field.
// - FSK: settle whole interval, sample once at its end.
// - OOK: settle one interval, then track peak over a second interval.
module rx_quality_indicators_antenna_diversity
#(
	parameter int CNT_W = 29
)
(
	input  wire logic                  sys_clk,
	input  wire logic                  rstn,
	input  wire rxq_pkg::axil_req_type s_axi_req,
	output var  rxq_pkg::axil_rsp_type s_axi_rsp,
	input  wire rxq_pkg::demod_type    demod,
	output logic                       carrier_sense,
	output logic                       antenna_switch,
	output logic                       rx_data,
	output logic                       rx_data_valid,
	output logic                       preamble_valid,
	output logic                       sync_valid
);
	import rxq_pkg::*;

	typedef enum {AS_IDLE, AS_SETTLE, AS_MEASURE, AS_FROZEN} as_state_type;

	function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction

	function automatic logic [SQI_W-1:0] correlate(input logic [SYNC_W-1:0] a,
		input logic [SYNC_W-1:0] b, input logic [SQI_W-1:0] len);
		logic [SQI_W-1:0] cnt;
		cnt = '0;
		for (int i = 0; i < SYNC_W; i++)
		begin
			if ((i < int'(len)) && (a[i] == b[i]))
				cnt = cnt + 1'b1;
		end
		return cnt;
	endfunction

	function automatic logic [CNT_W-1:0] meas_reload(input logic [3:0] e,
		input logic [2:0] m);
		logic [CNT_W-1:0] len;
		len = CNT_W'(MEAS_BASE) << (5'(e) + 5'(m));
		return len - 1'b1;
	endfunction

	ctrl_type          ctrl_ff;
	thresh_type        thr_ff;
	ant_type           antc_ff;
	as_state_type      as_state_ff;
	logic [SYNC_W-1:0] sync0_ff, sync1_ff, shift_ff;
	logic [DATA_W-1:0] rdata_ff, wdata_ff, nxt_rdata;
	logic [ADDR_W-1:0] waddr_ff;
	logic [CNT_W-1:0]  as_cnt_ff, as_reload;
	logic [LVL_W-1:0]  capt_lvl_ff, run_lvl_ff, cs_ref_ff, pqi_ff, pqi_peak_ff, as_peak_ff;
	logic [LVL_W-1:0]  as_pwr_ff [2];
	logic [LVL_W:0]    rssi9, th9, ref9, cs_step;
	logic [SQI_W-1:0]  seen_ff, sqi_peak_ff, corr0, corr1;
	logic [3:0]        wstrb_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic              aw_have_ff, w_have_ff, wr_fire, wr_ok, nxt_rd_ok;
	logic              rx_on_d_ff, rx_entry, prev_bit_ff, have_prev_ff;
	logic              pqi_hit_ff, sqi_sec_ff, sqi_hit_ff, sync_full;

	assign s_axi_rsp = '{awready_ff, wready_ff, bresp_ff, bvalid_ff, arready_ff, rdata_ff,
		rresp_ff, rvalid_ff};

	// -------------------------------------------------------------
	// Register bus: write path
	// -------------------------------------------------------------
	assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
	assign wr_ok = (waddr_ff == REG_CTRL) || (waddr_ff == REG_THRESH) ||
		(waddr_ff == REG_ANT) || (waddr_ff == REG_SYNC0) || (waddr_ff == REG_SYNC1);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			awready_ff <= 1'b0;
			aw_have_ff <= 1'b0;
			waddr_ff   <= '0;
		end
		else if (s_axi_req.awvalid && awready_ff)
		begin
			awready_ff <= 1'b0;
			aw_have_ff <= 1'b1;
			waddr_ff   <= s_axi_req.awaddr;
		end
		else if (wr_fire)
			aw_have_ff <= 1'b0;
		else if (!aw_have_ff && !bvalid_ff)
			awready_ff <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wready_ff <= 1'b0;
			w_have_ff <= 1'b0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end
		else if (s_axi_req.wvalid && wready_ff)
		begin
			wready_ff <= 1'b0;
			w_have_ff <= 1'b1;
			wdata_ff  <= s_axi_req.wdata;
			wstrb_ff  <= s_axi_req.wstrb;
		end
		else if (wr_fire)
			w_have_ff <= 1'b0;
		else if (!w_have_ff && !bvalid_ff)
			wready_ff <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_ff && s_axi_req.bready)
			bvalid_ff <= 1'b0;
	end

	// Reserved bits are masked on write so they always read back as zero
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_ff  <= ctrl_type'(CTRL_RST);
			thr_ff   <= thresh_type'(THRESH_RST);
			antc_ff  <= ant_type'(ANT_RST);
			sync0_ff <= SYNC_RST;
			sync1_ff <= SYNC_RST;
		end
		else if (wr_fire)
		begin
			case (waddr_ff)
				REG_CTRL:
					ctrl_ff <= ctrl_type'(merge_bytes(ctrl_ff, wdata_ff, wstrb_ff) & CTRL_WMASK);
				REG_THRESH:
					thr_ff <= thresh_type'(merge_bytes(thr_ff, wdata_ff, wstrb_ff) & THRESH_WMASK);
				REG_ANT:
					antc_ff <= ant_type'(merge_bytes(antc_ff, wdata_ff, wstrb_ff) & ANT_WMASK);
				REG_SYNC0:
					sync0_ff <= merge_bytes(sync0_ff, wdata_ff, wstrb_ff);
				REG_SYNC1:
					sync1_ff <= merge_bytes(sync1_ff, wdata_ff, wstrb_ff);
				default: ;
			endcase
		end
	end

	// -------------------------------------------------------------
	// Register bus: read path
	// -------------------------------------------------------------
	always_comb
	begin
		nxt_rdata = '0;
		nxt_rd_ok = 1'b1;
		case (s_axi_req.araddr)
			REG_CTRL:   nxt_rdata = ctrl_ff;
			REG_THRESH: nxt_rdata = thr_ff;
			REG_ANT:    nxt_rdata = antc_ff;
			REG_SYNC0:  nxt_rdata = sync0_ff;
			REG_SYNC1:  nxt_rdata = sync1_ff;
			REG_CAPT:   nxt_rdata = DATA_W'(capt_lvl_ff);
			REG_RUN:    nxt_rdata = DATA_W'(run_lvl_ff);
			REG_PQI:    nxt_rdata = DATA_W'(pqi_peak_ff);
			REG_SQI:
			begin
				nxt_rdata = DATA_W'(sqi_peak_ff);
				nxt_rdata[SQI_SEC_BIT] = sqi_sec_ff;
			end
			REG_STAT:
			begin
				nxt_rdata[STAT_CS]  = carrier_sense;
				nxt_rdata[STAT_ANT] = antenna_switch;
				nxt_rdata[STAT_PQV] = pqi_hit_ff;
				nxt_rdata[STAT_SQV] = sqi_hit_ff;
			end
			default:    nxt_rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end
		else if (s_axi_req.arvalid && arready_ff)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_ff && s_axi_req.rready)
		begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
		else if (!rvalid_ff)
			arready_ff <= 1'b1;
	end

	// -------------------------------------------------------------
	// Signal level capture
	// -------------------------------------------------------------
	assign rx_entry = demod.rx_on && !rx_on_d_ff;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rx_on_d_ff <= 1'b0;
		else
			rx_on_d_ff <= demod.rx_on;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			run_lvl_ff  <= '0;
			capt_lvl_ff <= '0;
		end
		else
		begin
			run_lvl_ff <= demod.rssi;
			if (demod.sync_end || demod.abort_command || demod.rx_timeout)
				capt_lvl_ff <= demod.rssi;
		end
	end

	// -------------------------------------------------------------
	// Carrier sense
	// -------------------------------------------------------------
	assign rssi9   = {1'b0, demod.rssi};
	assign th9     = {1'b0, thr_ff.signal_threshold};
	assign ref9    = {1'b0, cs_ref_ff};
	assign cs_step = (LVL_W+1)'(ctrl_ff.cs_mode * CS_DYN_STEP_DB);

	// Reference keeps the last trough or crest, so steps count from an extreme
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			carrier_sense <= 1'b0;
			cs_ref_ff     <= LVL_MAX;
		end
		else if (rx_entry)
		begin
			carrier_sense <= 1'b0;
			cs_ref_ff     <= LVL_MAX;
		end
		else if (ctrl_ff.cs_mode == 2'd0)
		begin
			if (!carrier_sense && (rssi9 > th9))
				carrier_sense <= 1'b1;
			else if (carrier_sense && (rssi9 + CS_HYST_DB <= th9))
				carrier_sense <= 1'b0;
		end
		else if (!carrier_sense)
		begin
			if ((rssi9 > th9) && (rssi9 >= ref9 + cs_step))
			begin
				carrier_sense <= 1'b1;
				cs_ref_ff     <= demod.rssi;
			end
			else if (demod.rssi < cs_ref_ff)
				cs_ref_ff <= demod.rssi;
		end
		else
		begin
			if (rssi9 + cs_step <= ref9)
			begin
				carrier_sense <= 1'b0;
				cs_ref_ff     <= demod.rssi;
			end
			else if (demod.rssi > cs_ref_ff)
				cs_ref_ff <= demod.rssi;
		end
	end

	// -------------------------------------------------------------
	// Preamble quality
	// -------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prev_bit_ff  <= 1'b0;
			have_prev_ff <= 1'b0;
			pqi_ff       <= '0;
			pqi_peak_ff  <= '0;
		end
		else if (rx_entry)
		begin
			have_prev_ff <= 1'b0;
			pqi_ff       <= '0;
			pqi_peak_ff  <= '0;
		end
		else if (demod.bit_valid)
		begin
			prev_bit_ff  <= demod.bit_val;
			have_prev_ff <= 1'b1;
			if (have_prev_ff && (demod.bit_val != prev_bit_ff) && (pqi_ff != LVL_MAX))
				pqi_ff <= pqi_ff + PQI_INC;
			else if (have_prev_ff && (demod.bit_val == prev_bit_ff))
				pqi_ff <= (pqi_ff > PQI_DEC) ? pqi_ff - PQI_DEC : '0;
		end
		else if (pqi_ff > pqi_peak_ff)
			pqi_peak_ff <= pqi_ff;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pqi_hit_ff     <= 1'b0;
			preamble_valid <= 1'b0;
		end
		else
		begin
			preamble_valid <= 1'b0;
			if (rx_entry)
				pqi_hit_ff <= 1'b0;
			else if (!pqi_hit_ff &&
				(pqi_peak_ff > (LVL_W'(thr_ff.preamble_quality_threshold) << PREAMBLE_QUALITY_THRESHOLD_SHIFT)))
			begin
				pqi_hit_ff     <= 1'b1;
				preamble_valid <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------
	// Sync quality
	// -------------------------------------------------------------
	assign corr0     = correlate(shift_ff, sync0_ff, thr_ff.sync_word_length);
	assign corr1     = correlate(shift_ff, sync1_ff, thr_ff.sync_word_length);
	assign sync_full = seen_ff >= thr_ff.sync_word_length;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			shift_ff    <= '0;
			seen_ff     <= '0;
			sqi_peak_ff <= '0;
			sqi_sec_ff  <= 1'b0;
		end
		else if (rx_entry)
		begin
			seen_ff     <= '0;
			sqi_peak_ff <= '0;
			sqi_sec_ff  <= 1'b0;
		end
		else
		begin
			if (demod.bit_valid)
			begin
				shift_ff <= {shift_ff[SYNC_W-2:0], demod.bit_val};
				if (seen_ff < SQI_W'(SYNC_W))
					seen_ff <= seen_ff + 1'b1;
			end
			if (sync_full && (corr1 > corr0) && (corr1 > sqi_peak_ff))
			begin
				sqi_peak_ff <= corr1;
				sqi_sec_ff  <= 1'b1;
			end
			else if (sync_full && (corr0 > sqi_peak_ff))
			begin
				sqi_peak_ff <= corr0;
				sqi_sec_ff  <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sqi_hit_ff <= 1'b0;
			sync_valid <= 1'b0;
		end
		else
		begin
			sync_valid <= 1'b0;
			if (rx_entry)
				sqi_hit_ff <= 1'b0;
			else if (!sqi_hit_ff && (ctrl_ff.sync_quality_check_enable ?
				((SQI_W+1)'(sqi_peak_ff) + ((SQI_W+1)'(thr_ff.sync_quality_threshold)
				<< SYNC_QUALITY_THRESHOLD_SHIFT) >= (SQI_W+1)'(thr_ff.sync_word_length)) :
				demod.sync_end))
			begin
				sqi_hit_ff <= 1'b1;
				sync_valid <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------
	// Data blanking
	// -------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_data       <= 1'b0;
			rx_data_valid <= 1'b0;
		end
		else
		begin
			rx_data       <= demod.bit_val;
			rx_data_valid <= demod.bit_valid && !(ctrl_ff.blank_en &&
				(demod.rssi < thr_ff.signal_threshold));
		end
	end

	// -------------------------------------------------------------
	// Antenna diversity
	// -------------------------------------------------------------
	// interval length
	assign as_reload = meas_reload(antc_ff.channel_filter_setting,
		antc_ff.antenna_measure_time_exp);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			as_state_ff    <= AS_IDLE;
			as_cnt_ff      <= '0;
			as_peak_ff     <= '0;
			as_pwr_ff[0]   <= '0;
			as_pwr_ff[1]   <= '0;
			antenna_switch <= 1'b0;
		end
		else if (rx_entry || !demod.rx_on || !ctrl_ff.antenna_diversity_enable)
		begin
			as_state_ff  <= AS_IDLE;
			as_pwr_ff[0] <= '0;
			as_pwr_ff[1] <= '0;
			if (rx_entry)
				antenna_switch <= 1'b0;
		end
		else
		begin
			case (as_state_ff)
				AS_IDLE:
				begin
					as_state_ff <= AS_SETTLE;
					as_cnt_ff   <= as_reload;
				end
				AS_SETTLE, AS_MEASURE:
				begin
					if (as_state_ff == AS_MEASURE && demod.rssi > as_peak_ff)
						as_peak_ff <= demod.rssi;
					if (carrier_sense)
					begin
						as_state_ff <= AS_FROZEN;
						if (as_pwr_ff[~antenna_switch] > as_pwr_ff[antenna_switch])
							antenna_switch <= ~antenna_switch;
					end
					else if (as_cnt_ff != '0)
						as_cnt_ff <= as_cnt_ff - 1'b1;
					else if (as_state_ff == AS_SETTLE && ctrl_ff.ook)
					begin
						as_state_ff <= AS_MEASURE;
						as_cnt_ff   <= as_reload;
						as_peak_ff  <= demod.rssi;
					end
					else
					begin
						as_pwr_ff[antenna_switch] <= (as_state_ff == AS_MEASURE &&
							as_peak_ff > demod.rssi) ? as_peak_ff : demod.rssi;
						antenna_switch <= ~antenna_switch;
						as_state_ff    <= AS_SETTLE;
						as_cnt_ff      <= as_reload;
					end
				end
				AS_FROZEN:
					as_state_ff <= AS_FROZEN;
				default:
					as_state_ff <= AS_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== rxq_demod_model.sv ====
// Demodulator side model: level, bit stream and receive events
`timescale 1ns/10ps
`default_nettype none
module rxq_demod_model
#(
	parameter logic [31:0] PAT = 32'h5555_5555
)
(
	input  wire logic               sys_clk,
	input  wire logic               rstn,
	input  wire logic               rx_en,
	input  wire logic [7:0]         lvl,
	input  wire logic               go,
	input  wire logic [2:0]         evt,
	output var  rxq_pkg::demod_type demod
);
	import rxq_pkg::*;
	logic [5:0] left_ff;
	logic [1:0] phase_ff;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			demod    <= '0;
			left_ff  <= 6'h00;
			phase_ff <= 2'h0;
		end
		else
		begin
			demod.rx_on <= rx_en;
			demod.rssi  <= lvl;
			{demod.sync_end, demod.abort_command, demod.rx_timeout} <= evt;
			phase_ff <= phase_ff + 2'h1;
			demod.bit_valid <= (left_ff != 6'h00) && (phase_ff == 2'h0);
			// Idle line keeps moving so stale data never looks valid
			demod.bit_val <= ~demod.bit_val;
			if (go)
				left_ff <= 6'h20;
			else if ((left_ff != 6'h00) && (phase_ff == 2'h0))
			begin
				left_ff       <= left_ff - 6'h01;
				demod.bit_val <= PAT[5'(left_ff - 6'h01)];
			end
		end
	end
endmodule
`default_nettype wire

// ==== rx_quality_indicators_antenna_diversity_assertions.sv ====
// Port-level assertions for the receiver quality block
`timescale 1ns/10ps
`default_nettype none
module rxq_assertions
#(
	parameter int CNT_W = 29
)
(
	input wire logic                  sys_clk,
	input wire logic                  rstn,
	input wire rxq_pkg::axil_req_type s_axi_req,
	input wire rxq_pkg::axil_rsp_type s_axi_rsp,
	input wire rxq_pkg::demod_type    demod,
	input wire logic                  carrier_sense,
	input wire logic                  antenna_switch,
	input wire logic                  rx_data,
	input wire logic                  rx_data_valid,
	input wire logic                  preamble_valid,
	input wire logic                  sync_valid
);
	import rxq_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	property p_data;
		rx_data_valid |-> $past(demod.bit_valid) && rx_data == $past(demod.bit_val);
	endproperty
	a_data: assert property (p_data) else $error("data without bit");
	property p_pv;
		preamble_valid |=> !preamble_valid [*8];
	endproperty
	a_pv: assert property (p_pv) else $error("preamble pulse repeats");
	property p_sv;
		sync_valid |=> !sync_valid;
	endproperty
	a_sv: assert property (p_sv) else $error("sync pulse too long");
	property p_cs;
		$rose(carrier_sense) |-> $past(demod.rssi) != 8'h00;
	endproperty
	a_cs: assert property (p_cs) else $error("sense on zero level");
	property p_entry;
		$rose(demod.rx_on) |-> ##[1:2] !antenna_switch && !carrier_sense;
	endproperty
	a_entry: assert property (p_entry) else $error("entry not cleared");
	property p_hold;
		!demod.rx_on && !$past(demod.rx_on) |-> $stable(antenna_switch);
	endproperty
	a_hold: assert property (p_hold) else $error("switch moved idle");
	// Shortest interval is 24 cycles, so eight quiet cycles always hold
	property p_gap;
		$changed(antenna_switch) && !carrier_sense |=> (carrier_sense || $stable(antenna_switch)
			|| !($past(demod.rx_on, 2) && $past(demod.rx_on, 3))) [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("switch too fast");
	property p_rd;
		s_axi_req.arvalid && s_axi_rsp.arready |=> s_axi_rsp.rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
endmodule
`default_nettype wire

// ==== rx_quality_indicators_antenna_diversity_tb.sv ====
// Self-checking bench for the receiver quality block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module rx_quality_indicators_antenna_diversity_tb;
	import rxq_pkg::*;
	logic         sys_clk, rstn, carrier_sense, antenna_switch, rx_data, rx_data_valid;
	logic         preamble_valid, sync_valid, rx_en, go, ant_q;
	axil_req_type s_axi_req;
	axil_rsp_type s_axi_rsp;
	demod_type    demod;
	logic [7:0]   lvl;
	logic [2:0]   evt;
	int           fail_count = 0;
	int           num_checks = 0;
	int           pv_n = 0, sv_n = 0, dv_n = 0, tog_n = 0;
	rx_quality_indicators_antenna_diversity i_rx_quality_indicators_antenna_diversity (
		.sys_clk(sys_clk), .rstn(rstn), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp),
		.demod(demod), .carrier_sense(carrier_sense), .antenna_switch(antenna_switch),
		.rx_data(rx_data), .rx_data_valid(rx_data_valid), .preamble_valid(preamble_valid),
		.sync_valid(sync_valid));
	rxq_demod_model i_rxq_demod_model (.sys_clk(sys_clk), .rstn(rstn), .rx_en(rx_en),
		.lvl(lvl), .go(go), .evt(evt), .demod(demod));
	always @(posedge sys_clk)
	begin
		pv_n <= pv_n + int'(preamble_valid);
		sv_n <= sv_n + int'(sync_valid);
		dv_n <= dv_n + int'(rx_data_valid);
		tog_n <= tog_n + int'(antenna_switch !== ant_q);
		ant_q <= antenna_switch;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_ok = 1'b0;
		logic w_ok = 1'b0;
		@(posedge sys_clk);
		s_axi_req.awaddr <= a;
		s_axi_req.wdata <= d;
		s_axi_req.wstrb <= 4'hF;
		s_axi_req.awvalid <= 1'b1;
		s_axi_req.wvalid <= 1'b1;
		s_axi_req.bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge sys_clk);
			aw_ok = aw_ok | s_axi_rsp.awready;
			w_ok = w_ok | s_axi_rsp.wready;
			if (aw_ok)
				s_axi_req.awvalid <= 1'b0;
			if (w_ok)
				s_axi_req.wvalid <= 1'b0;
		end
		while (s_axi_rsp.bvalid !== 1'b1)
			@(posedge sys_clk);
		s_axi_req.bready <= 1'b0;
		`CHK("bresp", r, s_axi_rsp.bresp)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge sys_clk);
		s_axi_req.araddr <= a;
		s_axi_req.arvalid <= 1'b1;
		s_axi_req.rready <= 1'b1;
		do
			@(posedge sys_clk);
		while (s_axi_rsp.arready !== 1'b1);
		s_axi_req.arvalid <= 1'b0;
		do
			@(posedge sys_clk);
		while (s_axi_rsp.rvalid !== 1'b1);
		s_axi_req.rready <= 1'b0;
		`CHK("rdata", e, s_axi_rsp.rdata)
		`CHK("rresp", r, s_axi_rsp.rresp)
	endtask
	task automatic setl(input logic [7:0] v);
		@(posedge sys_clk);
		lvl <= v;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic enter(input logic [7:0] v);
		@(posedge sys_clk);
		rx_en <= 1'b0;
		@(posedge sys_clk);
		rx_en <= 1'b1;
		setl(v);
	endtask
	task automatic pkt(input logic [7:0] v);
		enter(v);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (140) @(posedge sys_clk);
	endtask
	task automatic t_regs;
		rd(REG_CTRL, CTRL_RST, RESP_OKAY);
		rd(REG_THRESH, THRESH_RST, RESP_OKAY);
		rd(REG_ANT, ANT_RST, RESP_OKAY);
		rd(8'h40, 32'h0000_0000, RESP_SLVERR);
		wr(REG_CAPT, 32'h0000_00FF, RESP_SLVERR);
		rd(REG_CAPT, 32'h0000_0000, RESP_OKAY);
	endtask
	task automatic t_capture;
		wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge sys_clk);
			lvl <= 8'h21 + 8'(i);
			evt <= 3'b100 >> i;
			@(posedge sys_clk);
			evt <= 3'b000;
			lvl <= 8'h90 + 8'(i);
			rd(REG_CAPT, 32'h21 + i, RESP_OKAY);
			rd(REG_RUN, 32'h90 + i, RESP_OKAY);
		end
		`CHK("sv0", 1, sv_n)
	endtask
	task automatic t_cs;
		wr(REG_THRESH, 32'h0010_0740, RESP_OKAY);
		enter(8'h41);
		`CHK("cs_on", 1'b1, carrier_sense)
		setl(8'h3E);
		`CHK("cs_hold", 1'b1, carrier_sense)
		setl(8'h3D);
		`CHK("cs_off", 1'b0, carrier_sense)
		for (int m = 1; m < 4; m++)
		begin
			wr(REG_CTRL, 32'h0000_0001 + 32'(8 * m), RESP_OKAY);
			enter(8'h10);
			setl(8'h50);
			`CHK("dyn_on", 1'b1, carrier_sense)
			setl(8'h50 - 8'(6 * m));
			`CHK("dyn_off", 1'b0, carrier_sense)
		end
	endtask
	task automatic t_packets;
		int p0;
		int s0;
		int d0;
		wr(REG_CTRL, 32'h0000_0005, RESP_OKAY);
		wr(REG_SYNC0, 32'h5555_5555, RESP_OKAY);
		p0 = pv_n;
		s0 = sv_n;
		d0 = dv_n;
		pkt(8'h50);
		rd(REG_PQI, 32'h0000_001F, RESP_OKAY);
		rd(REG_SQI, 32'h0000_0020, RESP_OKAY);
		`CHK("pv", p0 + 1, pv_n)
		`CHK("sv", s0 + 1, sv_n)
		`CHK("dv", d0 + 32, dv_n)
		// Threshold 32 sits one above the best score of this preamble
		wr(REG_THRESH, 32'h0010_0840, RESP_OKAY);
		wr(REG_SYNC0, 32'h0000_0000, RESP_OKAY);
		wr(REG_SYNC1, 32'h5555_5555, RESP_OKAY);
		pkt(8'h20);
		rd(REG_SQI, 32'h0000_0060, RESP_OKAY);
		rd(REG_STAT, 32'h0000_0008, RESP_OKAY);
		`CHK("pv2", p0 + 1, pv_n)
		`CHK("dv2", d0 + 32, dv_n)
	endtask
	task automatic t_antenna;
		int t0;
		logic a;
		for (int k = 0; k < 2; k++)
		begin
			wr(REG_CTRL, 32'h0000_0003 + 32'(32 * k), RESP_OKAY);
			enter(8'h20);
			t0 = tog_n;
			repeat (200) @(posedge sys_clk);
			`CHK("toggles", 1'b1, (tog_n - t0) inside {[7 >> k:9 >> k]})
			setl(8'h50);
			repeat (4) @(posedge sys_clk);
			a = antenna_switch;
			repeat (80) @(posedge sys_clk);
			`CHK("frozen", a, antenna_switch)
			rd(REG_STAT, {30'h0000_0000, a, 1'b1}, RESP_OKAY);
		end
	endtask
	task report_and_stop;
		$display("checks %0d fails %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Tests take about a thousand cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		report_and_stop();
	end
	initial
	begin
		rstn = 1'b0;
		s_axi_req = '0;
		rx_en = 1'b0;
		lvl = 8'h00;
		go = 1'b0;
		evt = 3'b000;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs();
		t_capture();
		t_cs();
		t_packets();
		t_antenna();
		report_and_stop();
	end
endmodule
bind rx_quality_indicators_antenna_diversity rxq_assertions #(.CNT_W(CNT_W)) i_rxq_assertions (
	.sys_clk(sys_clk), .rstn(rstn), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp),
	.demod(demod), .carrier_sense(carrier_sense), .antenna_switch(antenna_switch),
	.rx_data(rx_data), .rx_data_valid(rx_data_valid), .preamble_valid(preamble_valid),
	.sync_valid(sync_valid));
`default_nettype wire
